// >>> hdl/svtr_regs.sv
// Vendor tuning register bank of a three-port switch with the arbiter it steers.
// Assumes a one-cycle configuration access port and a preload port fed by the
// SMBus, I2C or EEPROM loader; all inputs come from logic on clk.
module svtr_regs #(
   parameter int NPORTS = 3,
   parameter logic [11:0] REPLAY_DEFAULT = 12'h0_1f4,
   parameter logic [13:0] ACK_DEFAULT = 14'h0_0c8
) (
   // Clock and reset.
   input wire logic clk,
   input wire logic rst,
   // Configuration access.
   input wire logic cfg_wr,
   input wire logic cfg_rd,
   input wire logic [7:0] cfg_addr,
   input wire logic [31:0] cfg_wdata,
   output logic [31:0] cfg_rdata,
   output logic cfg_hit,
   // Preload from SMBus, I2C or EEPROM.
   input wire logic pre_wr,
   input wire logic pre_eeprom,
   input wire logic [7:0] pre_addr,
   input wire logic [31:0] pre_wdata,
   // Link training and reset controls.
   input wire logic upstream_port,
   input wire logic upstream_link_down,
   output logic downstream_role_select,
   output logic hot_reset_downstream,
   // Timer values and VGA decode enable.
   output logic [11:0] replay_timeout,
   output logic [13:0] ack_latency,
   output logic vga_decode_en,
   // Forwarding controls.
   output logic store_forward,
   output logic [1:0] cut_through_thresh,
   // Port arbiter.
   input wire logic [NPORTS-1:0] arb_req,
   input wire logic [NPORTS-1:0] arb_credit_ok,
   output logic [NPORTS-1:0] arb_grant
);

   // Refuses port counts that the one-hot grant and its search cannot serve.
   if (NPORTS < 2 || NPORTS > 8) begin : g_bad_nports
      $error("NPORTS must be 2 to 8.");
   end

   logic [31:0] test_ctl0;
   logic [31:0] test_ctl1;
   logic [31:0] timer_set;
   logic [31:0] fwd_mode;
   logic role;

   // Address decode for software and preload accesses.
   wire sel_t0 = cfg_addr == svtr_pkg::OFF_PHY_TEST_CONTROL_0;
   wire sel_t1 = cfg_addr == svtr_pkg::OFF_PHY_TEST_CONTROL_1;
   wire sel_tm = cfg_addr == svtr_pkg::OFF_TIMER_SETTING;
   wire sel_fw = cfg_addr == svtr_pkg::OFF_FORWARDING_MODE;
   wire pre_t0 = pre_wr && pre_addr == svtr_pkg::OFF_PHY_TEST_CONTROL_0;
   wire pre_tm = pre_wr && pre_addr == svtr_pkg::OFF_TIMER_SETTING;
   wire pre_fw = pre_wr && pre_addr == svtr_pkg::OFF_FORWARDING_MODE;

   // Bits 14:13 of test control 0 are the only ones a preload moves, and only an EEPROM one.
   wire [31:0] t0_pmask = 32'h0000_0003 << svtr_pkg::BIT_PRELOAD_LO;
   wire [31:0] next_t0_pre = (test_ctl0 & ~t0_pmask) | (pre_wdata & t0_pmask);

   // Test control registers; an EEPROM preload overrides a same-cycle software write to test control 0.
   always_ff @(posedge clk) begin
      if (rst) begin
         test_ctl0 <= svtr_pkg::RST_PHY_TEST_CONTROL_0;
         test_ctl1 <= svtr_pkg::RST_PHY_TEST_CONTROL_1;
      end else begin
         if (cfg_wr && sel_t0) test_ctl0 <= cfg_wdata;
         if (cfg_wr && sel_t1) test_ctl1 <= cfg_wdata;
         if (pre_t0 && pre_eeprom) test_ctl0 <= next_t0_pre;
      end
   end

   // Of the preloads, only an EEPROM load may move the preloadable bits of test control 0.
   a_preload_eeprom: assert property (@(posedge clk) disable iff (rst)
      pre_t0 && !pre_eeprom && !(cfg_wr && sel_t0) |=> $stable(test_ctl0))
      else $error("Test control changed by a non-EEPROM preload.");
   a_preload_t0: assert property (@(posedge clk) disable iff (rst)
      pre_t0 && pre_eeprom |=>
      test_ctl0[svtr_pkg::BIT_PRELOAD_HI:svtr_pkg::BIT_PRELOAD_LO] == $past(pre_wdata[14:13]))
      else $error("EEPROM load missed the preloadable bits.");

   // Timer and forwarding settings; software sees read-only bits unchanged.
   wire [31:0] tm_sw = (timer_set & ~svtr_pkg::WMASK_TIMER_SETTING) |
                       (cfg_wdata & svtr_pkg::WMASK_TIMER_SETTING);
   wire [31:0] tm_pre = (timer_set & ~svtr_pkg::PMASK_TIMER_SETTING) |
                        (pre_wdata & svtr_pkg::PMASK_TIMER_SETTING);
   wire [31:0] fw_sw = cfg_wdata & svtr_pkg::WMASK_FORWARDING_MODE;
   wire [31:0] fw_pre = pre_wdata & svtr_pkg::WMASK_FORWARDING_MODE;

   always_ff @(posedge clk) begin
      if (rst) begin
         timer_set <= svtr_pkg::RST_TIMER_SETTING;
         fwd_mode <= svtr_pkg::RST_FORWARDING_MODE;
      end else if (pre_tm || pre_fw) begin
         if (pre_tm) timer_set <= tm_pre;
         if (pre_fw) fwd_mode <= fw_pre;
      end else begin
         if (cfg_wr && sel_tm) timer_set <= tm_sw;
         if (cfg_wr && sel_fw) fwd_mode <= fw_sw;
      end
   end

   // Software writes that no same-cycle preload overrides.
   wire sw_tm_wr = cfg_wr && sel_tm && !pre_tm && !pre_fw;
   wire sw_fw_wr = cfg_wr && sel_fw && !pre_tm && !pre_fw;

   // Written and preloaded fields land one cycle after the strobe.
   a_ack_write: assert property (@(posedge clk) disable iff (rst)
      sw_tm_wr |=> timer_set[svtr_pkg::ACK_LSB +: 14] == $past(cfg_wdata[29:16]))
      else $error("Ack latency field not written.");
   a_thresh_write: assert property (@(posedge clk) disable iff (rst)
      sw_fw_wr |=> fwd_mode[svtr_pkg::THRESH_LSB +: 2] == $past(cfg_wdata[2:1]))
      else $error("Threshold field not written.");
   a_preload_load: assert property (@(posedge clk) disable iff (rst)
      pre_tm |=> timer_set[svtr_pkg::REPLAY_LSB +: 12] == $past(pre_wdata[11:0]))
      else $error("Preload did not reach the replay field.");
   a_fwd_preload: assert property (@(posedge clk) disable iff (rst)
      pre_fw |=> fwd_mode[svtr_pkg::THRESH_LSB +: 2] == $past(pre_wdata[2:1]))
      else $error("Preload did not reach the threshold field.");
   a_reset_fwd: assert property (@(posedge clk)
      $past(rst) |-> fwd_mode == svtr_pkg::RST_FORWARDING_MODE)
      else $error("Forwarding mode reset value wrong.");
   // The capability-disable bits move only by preload; the reserved bit 15 never moves.
   a_timer_ro: assert property (@(posedge clk) disable iff (rst)
      !pre_tm |=> $stable(timer_set[15:13]))
      else $error("Read-only timer bits changed without preload.");

   // The link role follows bit 3 only while bit 1 permits a change.
   always_ff @(posedge clk) begin
      if (rst) begin
         role <= 1'b0;
      end else if (test_ctl0[svtr_pkg::BIT_ROLE_CHANGE_EN]) begin
         role <= test_ctl0[svtr_pkg::BIT_DOWNSTREAM_ROLE];
      end
   end
   assign downstream_role_select = role;

   // Hot reset goes downstream on upstream link loss unless disabled.
   assign hot_reset_downstream = upstream_port && upstream_link_down &&
                                 !test_ctl0[svtr_pkg::BIT_HOT_RESET_DIS];

   // Effective timer values choose the user field only when enabled.
   wire [11:0] user_replay = timer_set[svtr_pkg::REPLAY_LSB +: 12];
   wire [13:0] user_ack = timer_set[svtr_pkg::ACK_LSB +: 14];
   assign replay_timeout = timer_set[svtr_pkg::BIT_REPLAY_EN] ? user_replay
                                                              : REPLAY_DEFAULT;
   assign ack_latency = timer_set[svtr_pkg::BIT_ACK_EN] ? user_ack
                                                        : ACK_DEFAULT;
   assign vga_decode_en = timer_set[svtr_pkg::BIT_VGA_DECODE];

   // With the enable written clear the built-in value shows, with it set the user value.
   a_replay_builtin: assert property (@(posedge clk) disable iff (rst)
      sw_tm_wr && !cfg_wdata[svtr_pkg::BIT_REPLAY_EN] |=> replay_timeout == REPLAY_DEFAULT)
      else $error("Replay time-out not built-in while disabled.");
   a_ack_user: assert property (@(posedge clk) disable iff (rst)
      sw_tm_wr && cfg_wdata[svtr_pkg::BIT_ACK_EN] |=> ack_latency == $past(cfg_wdata[29:16]))
      else $error("Ack latency does not use the user value.");

   // Store-and-forward applies on the upstream port only; the threshold on every port.
   assign store_forward = upstream_port && fwd_mode[svtr_pkg::BIT_STORE_FORWARD];
   assign cut_through_thresh = fwd_mode[svtr_pkg::THRESH_LSB +: 2];

   // A write seen by the upstream port on the next cycle sets the forwarding mode.
   sequence s_fwd_write_up;
      sw_fw_wr ##1 upstream_port;
   endsequence
   a_store_fwd: assert property (@(posedge clk) disable iff (rst)
      s_fwd_write_up |-> store_forward == $past(cfg_wdata[svtr_pkg::BIT_STORE_FORWARD]))
      else $error("Store-and-forward does not follow its bit.");
   a_store_up_only: assert property (@(posedge clk) disable iff (rst)
      !upstream_port |-> !store_forward)
      else $error("Store-and-forward outside the upstream port.");

   // Read data mux; unmapped addresses read zero with no hit.
   assign cfg_hit = cfg_rd && (sel_t0 || sel_t1 || sel_tm || sel_fw);
   always_ff @(posedge clk) begin
      if (rst) begin
         cfg_rdata <= 32'h0000_0000;
      end else if (cfg_rd) begin
         cfg_rdata <= sel_t0 ? test_ctl0 : sel_t1 ? test_ctl1 :
                      sel_tm ? timer_set : sel_fw ? fwd_mode : 32'h0000_0000;
      end
   end

   // Read data stands until the next read; unmapped reads return zero.
   a_rdata_hold: assert property (@(posedge clk) disable iff (rst)
      !cfg_rd |=> $stable(cfg_rdata))
      else $error("Read data changed without a read.");
   a_unmapped_zero: assert property (@(posedge clk) disable iff (rst)
      cfg_rd && !cfg_hit |=> cfg_rdata == 32'h0000_0000)
      else $error("Unmapped read returned data.");
   a_rdata_read: assert property (@(posedge clk) disable iff (rst)
      cfg_rd && sel_t1 |=> cfg_rdata == $past(test_ctl1))
      else $error("Test control 1 read wrong.");

   // Round-robin arbiter with sticky or credit-aware selection.
   svtr_pkg::svtr_arb_state_type arb_state;
   logic [NPORTS-1:0] next_grant;
   logic [NPORTS-1:0] last_grant;
   wire sticky = fwd_mode[svtr_pkg::BIT_ARB_STICKY];
   wire [NPORTS-1:0] eligible = sticky ? arb_req : (arb_req & arb_credit_ok);
   wire hold = (arb_state == svtr_pkg::ARB_HOLD) && sticky &&
               |(arb_grant & arb_req);

   // Search from the port after the last grant for the next eligible one.
   always_comb begin
      int idx;
      next_grant = '0;
      idx = 0;
      for (int k = NPORTS; k >= 1; k--) begin
         for (int j = 0; j < NPORTS; j++) begin
            if (last_grant[j]) idx = (j + k) % NPORTS;
         end
         if (eligible[idx]) next_grant = NPORTS'(1) << idx;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         arb_state <= svtr_pkg::ARB_IDLE;
         arb_grant <= '0;
         last_grant <= NPORTS'(1);
      end else begin
         case (arb_state)
            svtr_pkg::ARB_IDLE: begin
               arb_grant <= next_grant;
               if (|next_grant) begin
                  last_grant <= next_grant;
                  arb_state <= svtr_pkg::ARB_HOLD;
               end
            end
            svtr_pkg::ARB_HOLD: begin
               if (!hold) begin
                  arb_grant <= next_grant;
                  if (|next_grant) last_grant <= next_grant;
                  else arb_state <= svtr_pkg::ARB_IDLE;
               end
            end
            default: arb_state <= svtr_pkg::ARB_IDLE;
         endcase
      end
   end

   // Checks on the register bank and arbiter.
   // Two cycles of open permission let the role settle on the select bit.
   sequence s_role_open;
      test_ctl0[svtr_pkg::BIT_ROLE_CHANGE_EN] ##1 test_ctl0[svtr_pkg::BIT_ROLE_CHANGE_EN];
   endsequence
   a_role_blocked: assert property (@(posedge clk) disable iff (rst)
      !test_ctl0[svtr_pkg::BIT_ROLE_CHANGE_EN] |=> $stable(role))
      else $error("Role changed while blocked.");
   a_hot_reset_gate: assert property (@(posedge clk) disable iff (rst)
      test_ctl0[svtr_pkg::BIT_HOT_RESET_DIS] |-> !hot_reset_downstream)
      else $error("Hot reset fired while disabled.");
   a_role_follow: assert property (@(posedge clk) disable iff (rst)
      s_role_open |-> role == $past(test_ctl0[svtr_pkg::BIT_DOWNSTREAM_ROLE]))
      else $error("Role does not follow select bit.");
   a_reset_test0: assert property (@(posedge clk)
      $past(rst) |-> test_ctl0 == svtr_pkg::RST_PHY_TEST_CONTROL_0)
      else $error("Test control reset value wrong.");
   a_replay_write: assert property (@(posedge clk) disable iff (rst)
      cfg_wr && sel_tm && !pre_tm && !pre_fw |=> user_replay == $past(cfg_wdata[11:0]))
      else $error("Replay field not written.");
   a_replay_select: assert property (@(posedge clk) disable iff (rst)
      sw_tm_wr && cfg_wdata[svtr_pkg::BIT_REPLAY_EN] |=> replay_timeout == $past(cfg_wdata[11:0]))
      else $error("Replay time-out selection wrong.");
   a_ack_select: assert property (@(posedge clk) disable iff (rst)
      sw_tm_wr && !cfg_wdata[svtr_pkg::BIT_ACK_EN] |=> ack_latency == ACK_DEFAULT)
      else $error("Ack latency not built-in while disabled.");
   a_vga_readonly: assert property (@(posedge clk) disable iff (rst)
      !pre_tm |=> $stable(vga_decode_en))
      else $error("VGA decode changed without preload.");

   // Grant checks; without the sticky bit every grant must have had credit.
   a_sticky_hold: assert property (@(posedge clk) disable iff (rst)
      hold |=> arb_grant == $past(arb_grant))
      else $error("Sticky grant moved.");
   a_credit_grant: assert property (@(posedge clk) disable iff (rst)
      !$past(sticky) && |arb_grant |-> |($past(arb_req & arb_credit_ok) & arb_grant))
      else $error("Grant to port without credit.");
   a_grant_onehot: assert property (@(posedge clk) disable iff (rst)
      $onehot0(arb_grant))
      else $error("Grant is not one-hot.");
   a_grant_idle: assert property (@(posedge clk) disable iff (rst)
      arb_req == '0 |=> arb_grant == '0)
      else $error("Grant given without a request.");

endmodule

// >>> hdl/svtr_pkg.sv
// Package of the switch vendor tuning register bank: offsets, fields, resets, widths.
// Assumes a 32-bit configuration-space access port and a single clock domain.
package svtr_pkg;

   // Register offsets in configuration space.
   localparam logic [7:0] OFF_PHY_TEST_CONTROL_0 = 8'h68;
   localparam logic [7:0] OFF_PHY_TEST_CONTROL_1 = 8'h6c;
   localparam logic [7:0] OFF_TIMER_SETTING = 8'h70;
   localparam logic [7:0] OFF_FORWARDING_MODE = 8'h74;

   // Reset values.
   localparam logic [31:0] RST_PHY_TEST_CONTROL_0 = 32'h0400_1060;
   localparam logic [31:0] RST_PHY_TEST_CONTROL_1 = 32'h0400_0800;
   localparam logic [31:0] RST_TIMER_SETTING = 32'h8000_0000;
   localparam logic [31:0] RST_FORWARDING_MODE = 32'h0000_0002;

   // Test control 0 bit positions.
   localparam int BIT_ROLE_CHANGE_EN = 1;
   localparam int BIT_HOT_RESET_DIS = 2;
   localparam int BIT_DOWNSTREAM_ROLE = 3;
   localparam int BIT_PRELOAD_LO = 13;
   localparam int BIT_PRELOAD_HI = 14;

   // Timer setting fields.
   localparam int REPLAY_LSB = 0;
   localparam int REPLAY_WIDTH = 12;
   localparam int BIT_REPLAY_EN = 12;
   localparam int BIT_PM_CAP_DIS = 13;
   localparam int BIT_MSI_CAP_DIS = 14;
   localparam int ACK_LSB = 16;
   localparam int ACK_WIDTH = 14;
   localparam int BIT_ACK_EN = 30;
   localparam int BIT_VGA_DECODE = 31;

   // Forwarding mode fields.
   localparam int BIT_STORE_FORWARD = 0;
   localparam int THRESH_LSB = 1;
   localparam int BIT_ARB_STICKY = 3;

   // Writable masks for software writes.
   localparam logic [31:0] WMASK_TIMER_SETTING = 32'h7fff_1fff;
   localparam logic [31:0] WMASK_FORWARDING_MODE = 32'h0000_000f;
   // Timer setting bits that a preload may change: all but bit 15.
   localparam logic [31:0] PMASK_TIMER_SETTING = 32'hffff_7fff;

   // Arbiter state encodings.
   typedef enum logic [1:0] {
      ARB_IDLE = 2'b00,
      ARB_HOLD = 2'b01
   } svtr_arb_state_type;

endpackage

// >>> tb/svtr_regs_test.sv
// Self-checking bench of the vendor tuning register bank and its port arbiter.
// Assumes the one-cycle access and preload ports; inputs move at the falling edge.
module svtr_regs_test;
   timeunit 1ns;
   timeprecision 100ps;

   // Built-in timer values handed to the bank, distinct from its defaults.
   localparam logic [11:0] RPL_DEF = 12'h3a5;
   localparam logic [13:0] ACK_DEF = 14'h0123;

   // Stimulus and observed signals.
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic cfg_wr = 1'b0;
   logic cfg_rd = 1'b0;
   logic [7:0] cfg_addr = 8'h00;
   logic [31:0] cfg_wdata = 32'h0000_0000;
   logic [31:0] cfg_rdata;
   logic cfg_hit;
   logic pre_wr = 1'b0;
   logic pre_eeprom = 1'b0;
   logic [7:0] pre_addr = 8'h00;
   logic [31:0] pre_wdata = 32'h0000_0000;
   logic upstream_port = 1'b1;
   logic upstream_link_down = 1'b0;
   logic role;
   logic hot_rst;
   logic [11:0] replay_timeout;
   logic [13:0] ack_latency;
   logic vga;
   logic store_forward;
   logic [1:0] thresh;
   logic [2:0] arb_req = 3'h0;
   logic [2:0] arb_credit_ok = 3'h0;
   logic [2:0] arb_grant;
   int error_cnt = 0;
   int samples_checked = 0;

   svtr_regs #(.NPORTS(3), .REPLAY_DEFAULT(RPL_DEF), .ACK_DEFAULT(ACK_DEF)) dut (
      .clk(clk), .rst(rst), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr),
      .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_hit(cfg_hit), .pre_wr(pre_wr),
      .pre_eeprom(pre_eeprom), .pre_addr(pre_addr), .pre_wdata(pre_wdata),
      .upstream_port(upstream_port), .upstream_link_down(upstream_link_down),
      .downstream_role_select(role), .hot_reset_downstream(hot_rst),
      .replay_timeout(replay_timeout), .ack_latency(ack_latency), .vga_decode_en(vga),
      .store_forward(store_forward), .cut_through_thresh(thresh), .arb_req(arb_req),
      .arb_credit_ok(arb_credit_ok), .arb_grant(arb_grant));

   // The clock toggles every half period of 4 ns.
   always #4 clk = ~clk;

   // Compares one value and reports a mismatch at once.
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Prints the counts and the verdict, then stops the run.
   task automatic conclude();
      $display("Checks %0d, mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // One write strobe, then an idle cycle so strobes never meet in one time step.
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      cfg_wr = 1'b1;
      cfg_addr = a;
      cfg_wdata = d;
      @(negedge clk);
      cfg_wr = 1'b0;
      @(negedge clk);
   endtask

   // One read strobe; hit is seen with the strobe, data one cycle later.
   task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic hit);
      cfg_rd = 1'b1;
      cfg_addr = a;
      #1;
      check({31'h0, cfg_hit}, {31'h0, hit});
      @(negedge clk);
      cfg_rd = 1'b0;
      check(cfg_rdata, exp);
      @(negedge clk);
   endtask

   // One preload pulse from the loader.
   task automatic pre(input logic [7:0] a, input logic [31:0] d, input logic ee);
      pre_wr = 1'b1;
      pre_addr = a;
      pre_wdata = d;
      pre_eeprom = ee;
      @(negedge clk);
      pre_wr = 1'b0;
      @(negedge clk);
   endtask

   // Sets the arbiter inputs and checks the grant one cycle later.
   task automatic arb(input logic [2:0] r, input logic [2:0] c, input logic [2:0] g);
      arb_req = r;
      arb_credit_ok = c;
      @(negedge clk);
      check({29'h0, arb_grant}, {29'h0, g});
   endtask

   // Cuts a hung run short.
   initial begin
      #80000;
      error_cnt++;
      $display("Error at %0t ns: run did not finish", $time);
      conclude();
   end

   // Main sequence of register and arbiter scenarios.
   initial begin
      repeat (2) @(negedge clk);
      rst = 1'b0;
      rd(svtr_pkg::OFF_PHY_TEST_CONTROL_0, 32'h0400_1060, 1'b1);
      rd(svtr_pkg::OFF_PHY_TEST_CONTROL_1, 32'h0400_0800, 1'b1);
      rd(svtr_pkg::OFF_TIMER_SETTING, 32'h8000_0000, 1'b1);
      rd(svtr_pkg::OFF_FORWARDING_MODE, 32'h0000_0002, 1'b1);
      rd(8'h78, 32'h0000_0000, 1'b0);
      check({20'h0, replay_timeout}, {20'h0, RPL_DEF});
      upstream_link_down = 1'b1;
      #1 check({31'h0, hot_rst}, 32'h0000_0001);
      @(negedge clk);
      // Role moves only while the permission bit is set.
      wr(svtr_pkg::OFF_PHY_TEST_CONTROL_0, 32'h0400_1068);
      check({31'h0, role}, 32'h0000_0000);
      wr(svtr_pkg::OFF_PHY_TEST_CONTROL_0, 32'h0400_106a);
      check({31'h0, role}, 32'h0000_0001);
      wr(svtr_pkg::OFF_PHY_TEST_CONTROL_0, 32'h0400_1060);
      check({31'h0, role}, 32'h0000_0001);
      wr(svtr_pkg::OFF_PHY_TEST_CONTROL_0, 32'h0400_1064);
      check({31'h0, hot_rst}, 32'h0000_0000);
      // Timer fields, their enables and the read-only bits.
      wr(svtr_pkg::OFF_TIMER_SETTING, 32'hffff_ffff);
      rd(svtr_pkg::OFF_TIMER_SETTING, 32'hffff_1fff, 1'b1);
      check({20'h0, replay_timeout}, 32'h0000_0fff);
      check({18'h0, ack_latency}, 32'h0000_3fff);
      wr(svtr_pkg::OFF_TIMER_SETTING, 32'h0abc_0def);
      rd(svtr_pkg::OFF_TIMER_SETTING, 32'h8abc_0def, 1'b1);
      check({20'h0, replay_timeout}, {20'h0, RPL_DEF});
      check({18'h0, ack_latency}, {18'h0, ACK_DEF});
      wr(svtr_pkg::OFF_TIMER_SETTING, 32'h4abc_1def);
      check({20'h0, replay_timeout}, 32'h0000_0def);
      check({18'h0, ack_latency}, 32'h0000_0abc);
      // Preload paths override read-only bits; only an EEPROM one moves test control 0.
      pre(svtr_pkg::OFF_TIMER_SETTING, 32'h0000_0000, 1'b0);
      check({31'h0, vga}, 32'h0000_0000);
      pre(svtr_pkg::OFF_PHY_TEST_CONTROL_0, 32'hffff_ffff, 1'b0);
      rd(svtr_pkg::OFF_PHY_TEST_CONTROL_0, 32'h0400_1064, 1'b1);
      pre(svtr_pkg::OFF_PHY_TEST_CONTROL_0, 32'hffff_ffff, 1'b1);
      rd(svtr_pkg::OFF_PHY_TEST_CONTROL_0, 32'h0400_7064, 1'b1);
      // Every threshold code with store-and-forward on.
      for (int t = 0; t < 4; t++) begin
         wr(svtr_pkg::OFF_FORWARDING_MODE, {29'h0, t[1:0], 1'b1});
         check({30'h0, thresh}, t);
         check({31'h0, store_forward}, 32'h0000_0001);
      end
      upstream_port = 1'b0;
      #1 check({31'h0, store_forward}, 32'h0000_0000);
      @(negedge clk);
      wr(svtr_pkg::OFF_FORWARDING_MODE, 32'hffff_fff0);
      rd(svtr_pkg::OFF_FORWARDING_MODE, 32'h0000_0000, 1'b1);
      // Arbiter with and without the sticky grant.
      arb(3'b011, 3'b001, 3'b001);
      arb(3'b011, 3'b010, 3'b010);
      wr(svtr_pkg::OFF_FORWARDING_MODE, 32'h0000_0008);
      arb(3'b011, 3'b001, 3'b010);
      arb(3'b001, 3'b001, 3'b001);
      wr(svtr_pkg::OFF_FORWARDING_MODE, 32'h0000_0000);
      arb(3'b011, 3'b010, 3'b010);
      // A loader write to the forwarding mode keeps only its writable bits.
      pre(svtr_pkg::OFF_FORWARDING_MODE, 32'hffff_fff5, 1'b0);
      rd(svtr_pkg::OFF_FORWARDING_MODE, 32'h0000_0005, 1'b1);
      check({30'h0, thresh}, 32'h0000_0002);
      conclude();
   end
endmodule
